// ---- logic/pst_self_test.sv ----
// Operation
// - Program memory check first; fail halts, zeros
// - Then working memory; fail halts, all A
// - Then nonvolatile store; fail shows UNCALIBRATED
// - Any momentary key leaves UNCALIBRATED message
// - All pass: show bus address, revision
// - Then enter power-up default function
// - Program, 9, 3 starts diagnostic program
// - Diagnostic first lights all segments briefly
// - Diagnostic reruns same three memory tests
// - Then troubleshooting mode, step N 01
// - Function and range stay unchanged
// - Trigger advances diagnostic step
// - Other momentary key ends diagnostic program
// - Steps 01-04 select fixed measurement phases; in three-step setups step 04 clears all switches
// - Lowest DC volts: X10 signal steps only
// - AC coupling relay only in AC+DC
`timescale 1ns/100ps
module pst_self_test #(
   parameter int DISPLAY_TEST_CYCLES = pst_pkg::DISPLAY_TEST_CYCLES,
   parameter int IDENT_CYCLES = pst_pkg::IDENT_CYCLES
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire pst_pkg::pst_key_type key_in,
   input wire logic mem_test_done,
   input wire logic mem_test_pass,
   input wire pst_pkg::pst_func_type meas_func,
   input wire logic [2:0] meas_range,
   input wire logic ac_dc_coupling_sel,
   output logic mem_test_start,
   output pst_pkg::pst_mem_type mem_test_sel,
   output pst_pkg::pst_display_type display_out,
   output pst_pkg::pst_switch_type switch_out,
   output logic default_function_req,
   output logic locked_up
);

   localparam int TIMER_MAX = (DISPLAY_TEST_CYCLES > IDENT_CYCLES) ?
      DISPLAY_TEST_CYCLES : IDENT_CYCLES;
   localparam int TIMER_W = $clog2(TIMER_MAX + 1);
   localparam logic [TIMER_W-1:0] DISP_END = TIMER_W'(DISPLAY_TEST_CYCLES - 1);
   localparam logic [TIMER_W-1:0] IDENT_END = TIMER_W'(IDENT_CYCLES - 1);

   typedef enum logic [3:0] {
      st_test_req, st_test_wait, st_halt_program, st_halt_working, st_uncal,
      st_ident, st_normal, st_display_test, st_trouble
   } pst_state_type;

   typedef enum logic [1:0] {seq_idle, seq_program, seq_nine} pst_seq_type;

   pst_state_type state_q, state_d;
   pst_seq_type seq_q, seq_d;
   pst_pkg::pst_mem_type mem_q, mem_d;
   logic diag_q, diag_d;
   logic [1:0] step_q, step_d;
   logic [TIMER_W-1:0] timer_q, timer_d;
   logic start_q, start_d;
   logic default_q, default_d;
   logic lock_q, lock_d;
   pst_pkg::pst_display_type disp_q, disp_d;
   pst_pkg::pst_switch_type sw_q, sw_d;
   logic momentary_key;

   // Phase table for one function, range and step
   function automatic pst_pkg::pst_switch_type phase_lookup(
      input pst_pkg::pst_func_type func,
      input logic [2:0] range,
      input logic [1:0] step,
      input logic acdc
   );
      pst_pkg::pst_switch_type s;
      logic three_step;
      s = '0;
      s.func = func;
      s.range = range;
      s.enable = 1'b1;
      three_step = 1'b0;
      case (func)
         pst_pkg::func_dcv: begin
            three_step = (range != pst_pkg::DCV_200MV) && (range != pst_pkg::DCV_20V);
            case (step)
               2'h0: s.phase = pst_pkg::phase_input_measure;
               2'h1: s.phase = pst_pkg::phase_signal_zero;
               2'h2: s.phase = pst_pkg::phase_cal;
               default: s.phase = pst_pkg::phase_cal_zero;
            endcase
            s.gain_x10 = (range == pst_pkg::DCV_200MV) && !step[1];
         end
         pst_pkg::func_ohms: begin
            if (range > pst_pkg::OHM_200K) begin
               three_step = 1'b1;
               case (step)
                  2'h0: s.phase = pst_pkg::phase_ref_hi;
                  2'h1: s.phase = pst_pkg::phase_sense_hi;
                  default: s.phase = pst_pkg::phase_sense_lo;
               endcase
            end else begin
               case (step)
                  2'h0: s.phase = pst_pkg::phase_ref_hi;
                  2'h1: s.phase = pst_pkg::phase_ref_lo;
                  2'h2: s.phase = pst_pkg::phase_sense_hi;
                  default: s.phase = pst_pkg::phase_sense_lo;
               endcase
            end
            s.gain_x10 = (range == pst_pkg::OHM_200) && step[1];
         end
         default: begin
            three_step = 1'b1;
            case (step)
               2'h0: s.phase = pst_pkg::phase_input_measure;
               2'h1: s.phase = pst_pkg::phase_signal_zero;
               default: s.phase = pst_pkg::phase_cal;
            endcase
            s.ac_dc_coupling_relay = acdc &&
               ((func == pst_pkg::func_acv) || (func == pst_pkg::func_aci));
         end
      endcase
      if (three_step && (step == pst_pkg::STEP_LAST)) begin
         // Whole word cleared so no driver decodes a stale range
         s = '0;
      end
      return s;
   endfunction

   assign momentary_key = key_in.strobe && (key_in.kind != pst_pkg::key_none);

   always_comb begin
      state_d = state_q;
      seq_d = seq_q;
      mem_d = mem_q;
      diag_d = diag_q;
      step_d = step_q;
      timer_d = timer_q;
      start_d = 1'b0;
      default_d = 1'b0;
      lock_d = lock_q;
      disp_d = disp_q;
      sw_d = '0;
      case (state_q)
         st_test_req: begin
            start_d = 1'b1;
            state_d = st_test_wait;
         end
         st_test_wait: begin
            if (mem_test_done) begin
               if (mem_test_pass) begin
                  case (mem_q)
                     pst_pkg::mem_program: begin
                        mem_d = pst_pkg::mem_working;
                        state_d = st_test_req;
                     end
                     pst_pkg::mem_working: begin
                        mem_d = pst_pkg::mem_nonvolatile;
                        state_d = st_test_req;
                     end
                     default: begin
                        if (diag_q) begin
                           state_d = st_trouble;
                           step_d = pst_pkg::STEP_FIRST;
                           disp_d.mode = pst_pkg::disp_step;
                           disp_d.step_num = pst_pkg::STEP_DISPLAY_BASE;
                        end else begin
                           state_d = st_ident;
                           timer_d = '0;
                           disp_d.mode = pst_pkg::disp_address_revision;
                        end
                     end
                  endcase
               end else begin
                  case (mem_q)
                     pst_pkg::mem_program: begin
                        state_d = st_halt_program;
                        disp_d.mode = pst_pkg::disp_all_zeros;
                        lock_d = 1'b1;
                     end
                     pst_pkg::mem_working: begin
                        state_d = st_halt_working;
                        disp_d.mode = pst_pkg::disp_all_a;
                        lock_d = 1'b1;
                     end
                     default: begin
                        state_d = st_uncal;
                        disp_d.mode = pst_pkg::disp_uncalibrated;
                     end
                  endcase
               end
            end
         end
         st_halt_program, st_halt_working: begin
            lock_d = 1'b1;
         end
         st_uncal: begin
            if (momentary_key) begin
               state_d = st_normal;
               disp_d.mode = pst_pkg::disp_normal;
               default_d = !diag_q;
               diag_d = 1'b0;
            end
         end
         st_ident: begin
            if (timer_q == IDENT_END) begin
               state_d = st_normal;
               disp_d.mode = pst_pkg::disp_normal;
               default_d = 1'b1;
            end else begin
               timer_d = timer_q + 1'b1;
            end
         end
         st_normal: begin
            if (momentary_key) begin
               seq_d = seq_idle;
               if (key_in.kind == pst_pkg::key_program) begin
                  seq_d = seq_program;
               end else if (key_in.kind == pst_pkg::key_digit) begin
                  if (seq_q == seq_program && key_in.digit == pst_pkg::DIAG_DIGIT_FIRST) begin
                     seq_d = seq_nine;
                  end else if (seq_q == seq_nine &&
                               key_in.digit == pst_pkg::DIAG_DIGIT_SECOND) begin
                     state_d = st_display_test;
                     diag_d = 1'b1;
                     timer_d = '0;
                     disp_d.mode = pst_pkg::disp_all_on;
                  end
               end
            end
         end
         st_display_test: begin
            if (timer_q == DISP_END) begin
               state_d = st_test_req;
               mem_d = pst_pkg::mem_program;
               // Segments lit only for the timed interval, not the memory tests
               disp_d.mode = pst_pkg::disp_blank;
               seq_d = seq_idle;
            end else begin
               timer_d = timer_q + 1'b1;
            end
         end
         st_trouble: begin
            sw_d = phase_lookup(meas_func, meas_range, step_q, ac_dc_coupling_sel);
            if (key_in.strobe && key_in.kind == pst_pkg::key_trigger) begin
               if (step_q == pst_pkg::STEP_LAST) begin
                  step_d = pst_pkg::STEP_FIRST;
               end else begin
                  step_d = step_q + 2'h1;
               end
               disp_d.step_num = 4'({2'h0, step_d}) + pst_pkg::STEP_DISPLAY_BASE;
            end else if (momentary_key) begin
               state_d = st_normal;
               diag_d = 1'b0;
               disp_d.mode = pst_pkg::disp_normal;
               sw_d = '0;
            end
         end
         default: begin
            state_d = st_test_req;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= st_test_req;
         seq_q <= seq_idle;
         mem_q <= pst_pkg::mem_program;
         diag_q <= 1'b0;
         step_q <= 2'h0;
         timer_q <= '0;
         start_q <= 1'b0;
         default_q <= 1'b0;
         lock_q <= 1'b0;
         disp_q <= '0;
         sw_q <= '0;
      end else begin
         state_q <= state_d;
         seq_q <= seq_d;
         mem_q <= mem_d;
         diag_q <= diag_d;
         step_q <= step_d;
         timer_q <= timer_d;
         start_q <= start_d;
         default_q <= default_d;
         lock_q <= lock_d;
         disp_q <= disp_d;
         sw_q <= sw_d;
      end
   end

   assign mem_test_start = start_q;
   assign mem_test_sel = mem_q;
   assign display_out = disp_q;
   assign switch_out = sw_q;
   assign default_function_req = default_q;
   assign locked_up = lock_q;

endmodule // pst_self_test

// ---- logic/pst_pkg.sv ----
package pst_pkg;

   // Timing of the timed display phases
   localparam int CLK_MHZ = 100;
   localparam int DISPLAY_TEST_MS = 500;
   localparam int DISPLAY_TEST_CYCLES = DISPLAY_TEST_MS * 1000 * CLK_MHZ;
   localparam int IDENT_MS = 1000;
   localparam int IDENT_CYCLES = IDENT_MS * 1000 * CLK_MHZ;

   // Diagnostic step numbering
   localparam logic [1:0] STEP_FIRST = 2'h0;
   localparam logic [1:0] STEP_LAST = 2'h3;
   localparam logic [3:0] STEP_DISPLAY_BASE = 4'h1;

   // Digit keys that follow the program key
   localparam logic [3:0] DIAG_DIGIT_FIRST = 4'h9;
   localparam logic [3:0] DIAG_DIGIT_SECOND = 4'h3;

   // Range indices per function
   localparam logic [2:0] DCV_200MV = 3'h0;
   localparam logic [2:0] DCV_2V = 3'h1;
   localparam logic [2:0] DCV_20V = 3'h2;
   localparam logic [2:0] OHM_200 = 3'h0;
   localparam logic [2:0] OHM_200K = 3'h3;

   typedef enum logic [2:0] {
      key_none, key_program, key_digit, key_trigger, key_other
   } pst_key_kind_type;

   typedef struct packed {
      logic strobe;
      pst_key_kind_type kind;
      logic [3:0] digit;
   } pst_key_type;

   typedef enum logic [1:0] {mem_program, mem_working, mem_nonvolatile} pst_mem_type;

   typedef enum logic [2:0] {func_dcv, func_acv, func_ohms, func_dci, func_aci} pst_func_type;

   typedef enum logic [3:0] {
      phase_none, phase_input_measure, phase_signal_zero, phase_cal, phase_cal_zero,
      phase_ref_hi, phase_ref_lo, phase_sense_hi, phase_sense_lo
   } pst_phase_type;

   typedef enum logic [2:0] {
      disp_blank, disp_all_zeros, disp_all_a, disp_uncalibrated,
      disp_address_revision, disp_all_on, disp_step, disp_normal
   } pst_disp_mode_type;

   typedef struct packed {
      pst_disp_mode_type mode;
      logic [3:0] step_num;
   } pst_display_type;

   typedef struct packed {
      logic enable;
      logic gain_x10;
      pst_phase_type phase;
      pst_func_type func;
      logic [2:0] range;
      logic ac_dc_coupling_relay;
   } pst_switch_type;

endpackage

// ---- testbench/pst_mem_model.sv ----
`timescale 1ns/100ps
module pst_mem_model (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic mem_test_start,
   input wire pst_pkg::pst_mem_type mem_test_sel,
   input wire logic [2:0] fail_mask,
   input wire logic [3:0] latency,
   output logic mem_test_done,
   output logic mem_test_pass
);
   logic busy_q;
   logic [3:0] cnt_q;
   // Idle result line toggles so a stale verdict is never trusted
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
         cnt_q <= 4'h0;
         mem_test_done <= 1'b0;
         mem_test_pass <= 1'b0;
      end else begin
         mem_test_done <= 1'b0;
         mem_test_pass <= ~mem_test_pass;
         if (mem_test_start) begin
            busy_q <= 1'b1;
            cnt_q <= latency;
         end else if (busy_q && cnt_q == 4'h0) begin
            busy_q <= 1'b0;
            mem_test_done <= 1'b1;
            mem_test_pass <= ~fail_mask[mem_test_sel];
         end else if (busy_q) begin
            cnt_q <= cnt_q - 4'h1;
         end
      end
   end
endmodule // pst_mem_model

// ---- testbench/pst_self_test_properties.sv ----
`timescale 1ns/100ps
module pst_self_test_checker #(
   parameter int DISPLAY_TEST_CYCLES = 8,
   parameter int IDENT_CYCLES = 12
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire pst_pkg::pst_key_type key_in,
   input wire pst_pkg::pst_func_type meas_func,
   input wire logic [2:0] meas_range,
   input wire pst_pkg::pst_mem_type mem_test_sel,
   input wire pst_pkg::pst_display_type display_out,
   input wire pst_pkg::pst_switch_type switch_out,
   input wire logic default_function_req,
   input wire logic locked_up
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_halt;
      (locked_up && $stable(display_out))[*8];
   endsequence
   sequence s_ident;
      (display_out.mode == pst_pkg::disp_address_revision)[*8];
   endsequence
   property p_halt;
      $rose(locked_up) |-> display_out.mode inside
         {pst_pkg::disp_all_zeros, pst_pkg::disp_all_a} ##1 s_halt;
   endproperty
   a_halt: assert property (p_halt) else $error("halt not held");
   property p_ram_order;
      $changed(mem_test_sel) && mem_test_sel == pst_pkg::mem_working
         |-> $past(mem_test_sel) == pst_pkg::mem_program;
   endproperty
   a_ram_order: assert property (p_ram_order) else $error("working test out of order");
   property p_nv_order;
      $changed(mem_test_sel) && mem_test_sel == pst_pkg::mem_nonvolatile
         |-> $past(mem_test_sel) == pst_pkg::mem_working;
   endproperty
   a_nv_order: assert property (p_nv_order) else $error("store test out of order");
   property p_ident;
      $rose(display_out.mode == pst_pkg::disp_address_revision) |-> s_ident
         ##[1:8] (default_function_req && display_out.mode == pst_pkg::disp_normal);
   endproperty
   a_ident: assert property (p_ident) else $error("ident phase wrong");
   property p_dflt;
      default_function_req |-> $past(display_out.mode) inside
         {pst_pkg::disp_address_revision, pst_pkg::disp_uncalibrated};
   endproperty
   a_dflt: assert property (p_dflt) else $error("stray default request");
   property p_wrap;
      key_in.strobe && key_in.kind == pst_pkg::key_trigger
         && display_out.mode == pst_pkg::disp_step |=> display_out.step_num ==
         ($past(display_out.step_num) == 4'h4 ? 4'h1 : $past(display_out.step_num) + 4'h1);
   endproperty
   a_wrap: assert property (p_wrap) else $error("step advance wrong");
   property p_exit;
      key_in.strobe && display_out.mode == pst_pkg::disp_step && key_in.kind inside
         {pst_pkg::key_program, pst_pkg::key_digit, pst_pkg::key_other}
         |=> display_out.mode == pst_pkg::disp_normal && switch_out == '0;
   endproperty
   a_exit: assert property (p_exit) else $error("diagnostic exit wrong");
   property p_gain;
      display_out.mode == pst_pkg::disp_step && $past(display_out.mode) == pst_pkg::disp_step
         && meas_func == pst_pkg::func_dcv && $stable(meas_func) && meas_range == 3'h0
         && $stable(meas_range) |-> switch_out.gain_x10 == ($past(display_out.step_num) < 4'h3);
   endproperty
   a_gain: assert property (p_gain) else $error("buffer gain wrong");
   property p_swoff;
      display_out.mode != pst_pkg::disp_step && $past(display_out.mode) != pst_pkg::disp_step
         |-> switch_out == '0;
   endproperty
   a_swoff: assert property (p_swoff) else $error("switches on outside steps");
   property p_notest;
      display_out.mode == pst_pkg::disp_step && $past(display_out.mode) == pst_pkg::disp_step
         && meas_func inside {pst_pkg::func_acv, pst_pkg::func_aci, pst_pkg::func_dci}
         && $stable(meas_func) && $past(display_out.step_num) == 4'h4 |-> switch_out == '0;
   endproperty
   a_notest: assert property (p_notest) else $error("no-test step drives switches");
endmodule // pst_self_test_checker
bind pst_self_test pst_self_test_checker #(.DISPLAY_TEST_CYCLES(DISPLAY_TEST_CYCLES),
   .IDENT_CYCLES(IDENT_CYCLES)) chk (.sys_clk(sys_clk), .rst_n(rst_n), .key_in(key_in),
   .meas_func(meas_func), .meas_range(meas_range), .mem_test_sel(mem_test_sel),
   .display_out(display_out), .switch_out(switch_out),
   .default_function_req(default_function_req), .locked_up(locked_up));

// ---- testbench/pst_self_test_tb.sv ----
`timescale 1ns/100ps
module pst_self_test_tb;
   localparam int ID = 12;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   pst_pkg::pst_key_type key_in = '0;
   pst_pkg::pst_func_type meas_func = pst_pkg::func_dcv;
   logic [2:0] meas_range = 3'h0;
   logic ac_dc_coupling_sel = 1'b0;
   logic [2:0] fail_mask = 3'h0;
   logic [3:0] latency = 4'h0;
   logic mem_test_done, mem_test_pass, mem_test_start, default_function_req, locked_up;
   logic req_seen;
   pst_pkg::pst_mem_type mem_test_sel;
   pst_pkg::pst_display_type display_out;
   pst_pkg::pst_switch_type switch_out;
   int err_count = 0;
   int checks_done = 0;
   always #5 sys_clk = ~sys_clk;
   pst_self_test #(.DISPLAY_TEST_CYCLES(8), .IDENT_CYCLES(ID)) dut (.sys_clk(sys_clk),
      .rst_n(rst_n), .key_in(key_in), .mem_test_done(mem_test_done),
      .mem_test_pass(mem_test_pass), .meas_func(meas_func), .meas_range(meas_range),
      .ac_dc_coupling_sel(ac_dc_coupling_sel), .mem_test_start(mem_test_start),
      .mem_test_sel(mem_test_sel), .display_out(display_out), .switch_out(switch_out),
      .default_function_req(default_function_req), .locked_up(locked_up));
   pst_mem_model mem (.sys_clk(sys_clk), .rst_n(rst_n), .mem_test_start(mem_test_start),
      .mem_test_sel(mem_test_sel), .fail_mask(fail_mask), .latency(latency),
      .mem_test_done(mem_test_done), .mem_test_pass(mem_test_pass));
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict;
      $display("checks=%0d errors=%0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic wait_mode(input pst_pkg::pst_disp_mode_type m);
      int n;
      n = 0;
      while (display_out.mode !== m && n < 200) begin
         @(negedge sys_clk);
         n++;
      end
      check(16'(display_out.mode), 16'(m));
   endtask
   task automatic reset_dut(input logic [2:0] mask);
      fail_mask = mask;
      rst_n = 1'b0;
      repeat (3) @(negedge sys_clk);
      rst_n = 1'b1;
   endtask
   // Strobe dropped a full cycle before the next press, never in the same step
   task automatic press(input pst_pkg::pst_key_kind_type k, input logic [3:0] d);
      key_in = '{1'b1, k, d};
      @(negedge sys_clk);
      req_seen = default_function_req;
      key_in = '0;
      @(negedge sys_clk);
   endtask
   task automatic t_power_up;
      int n;
      latency = 4'h5;
      reset_dut(3'h0);
      @(negedge sys_clk);
      check(16'(mem_test_start), 16'h1);
      check(16'(mem_test_sel), 16'(pst_pkg::mem_program));
      @(negedge sys_clk);
      check(16'(mem_test_start), 16'h0);
      wait_mode(pst_pkg::disp_address_revision);
      n = 0;
      while (display_out.mode === pst_pkg::disp_address_revision && n < 50) begin
         n++;
         @(negedge sys_clk);
      end
      check(16'(n), 16'(ID));
      check(16'(default_function_req), 16'h1);
      check(16'(display_out.mode), 16'(pst_pkg::disp_normal));
      latency = 4'h0;
   endtask
   task automatic t_fail;
      pst_pkg::pst_disp_mode_type m [3] = '{pst_pkg::disp_all_zeros, pst_pkg::disp_all_a,
         pst_pkg::disp_uncalibrated};
      for (int i = 0; i < 3; i++) begin
         reset_dut(3'(1 << i));
         wait_mode(m[i]);
         // Halts ignore keys; a keyless strobe must not clear UNCALIBRATED
         press(i < 2 ? pst_pkg::key_trigger : pst_pkg::key_none, 4'h0);
         repeat (20) @(negedge sys_clk);
         check(16'(display_out.mode), 16'(m[i]));
         check(16'(locked_up), 16'(i < 2));
         check(16'(mem_test_sel), 16'(i));
      end
      press(pst_pkg::key_digit, 4'h0);
      check(16'(req_seen), 16'h1);
      check(16'(display_out.mode), 16'(pst_pkg::disp_normal));
   endtask
   task automatic t_diag;
      pst_pkg::pst_switch_type e;
      pst_pkg::pst_phase_type ph [4] = '{pst_pkg::phase_input_measure,
         pst_pkg::phase_signal_zero, pst_pkg::phase_cal, pst_pkg::phase_cal_zero};
      fail_mask = 3'h0;
      press(pst_pkg::key_program, 4'h0);
      press(pst_pkg::key_digit, 4'h9);
      press(pst_pkg::key_digit, 4'h4);
      check(16'(display_out.mode), 16'(pst_pkg::disp_normal));
      press(pst_pkg::key_program, 4'h0);
      press(pst_pkg::key_digit, 4'h9);
      press(pst_pkg::key_digit, 4'h3);
      check(16'(display_out.mode), 16'(pst_pkg::disp_all_on));
      wait_mode(pst_pkg::disp_step);
      check(16'(display_out.step_num), 16'h1);
      check(16'(mem_test_sel), 16'(pst_pkg::mem_nonvolatile));
      @(negedge sys_clk);
      for (int i = 0; i < 5; i++) begin
         e = '{1'b1, 1'(i % 4 < 2), ph[i % 4], pst_pkg::func_dcv, 3'h0, 1'b0};
         check(16'(switch_out), 16'(e));
         if (i < 4) begin
            press(pst_pkg::key_trigger, 4'h0);
            check(16'(display_out.step_num), 16'((i + 1) % 4 + 1));
         end
      end
      meas_func = pst_pkg::func_acv;
      ac_dc_coupling_sel = 1'b1;
      repeat (2) @(negedge sys_clk);
      e = '{1'b1, 1'b0, pst_pkg::phase_input_measure, pst_pkg::func_acv, 3'h0, 1'b1};
      check(16'(switch_out), 16'(e));
      ac_dc_coupling_sel = 1'b0;
      repeat (2) @(negedge sys_clk);
      check(16'(switch_out.ac_dc_coupling_relay), 16'h0);
      repeat (3) press(pst_pkg::key_trigger, 4'h0);
      check(16'(switch_out), 16'h0);
      press(pst_pkg::key_other, 4'h0);
      check(16'(display_out.mode), 16'(pst_pkg::disp_normal));
      check(16'(switch_out), 16'h0);
   endtask
   initial begin
      t_power_up;
      t_fail;
      t_diag;
      print_verdict;
   end
   initial begin
      #200000;
      err_count++;
      print_verdict;
   end
endmodule // pst_self_test_tb
